// >>> hdl/uart_flow_consts.svh
// Purpose: offsets, field positions, reset values and levels
// Assumes: byte addresses on an 8-bit APB address
// Notes:   definitions only
`ifndef UART_FLOW_CONSTS_SVH
`define UART_FLOW_CONSTS_SVH
// register byte offsets
`define OFS_DIV_LO   8'h00
`define OFS_DIV_HI   8'h04
`define OFS_FRAC     8'h08
`define OFS_INT_EN   8'h0C
`define OFS_FIFO_CTL 8'h10
`define OFS_INT_STAT 8'h14
`define OFS_LINE_CTL 8'h18
`define OFS_MDM_CTL  8'h1C
`define OFS_LINE_ST  8'h20
`define OFS_MDM_ST   8'h24
`define OFS_SCRATCH  8'h28
`define OFS_ENH      8'h2C
`define OFS_ON1      8'h30
`define OFS_ON2      8'h34
`define OFS_OFF1     8'h38
`define OFS_OFF2     8'h3C
`define OFS_EV_STAT  8'h40
`define OFS_EV_MASK  8'h44
// reset values
`define RST_ZERO     8'h00
`define RST_DIV_LO   8'h01
`define RST_INT_STAT 8'h01
`define RST_LINE_ST  8'h60
`define RST_SCRATCH  8'hFF
// field positions
`define ENH_UNLOCK   4
`define ENH_ARTS     6
`define ENH_ACTS     7
`define MC_DTR       0
`define MC_RTS       1
`define MC_OP2       3
`define FC_FIFO_EN   0
// bits that only an unlocked enhanced register lets through
`define MASK_INT_EN  8'hF0
`define MASK_FIFO    8'h30
`define MASK_MDM     8'hE0
// receive fill levels
`define LVL_T0       6'h08
`define LVL_T1       6'h10
`define LVL_T2       6'h18
`define LVL_T3       6'h1C
`define LVL_TOP      6'h20
`define LVL_BOT      6'h04
// event bits
`define EV_TRIG      0
`define EV_CTS       1
`define EV_RTS       2
`define EV_W         3
`endif

// >>> hdl/uart_flow_pkg.sv
// Purpose: shared types
// Assumes: nothing
// Notes:   constants live in uart_flow_consts.svh
`default_nettype none
package uart_flow_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] level_t;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WAIT = 3'b010,
        ACC_DONE = 3'b100
    } acc_state_t;
endpackage
`default_nettype wire

// >>> hdl/pace_if.sv
// Purpose: carries fill level and pacing result
// Assumes: one clock
// Notes:   ctrl drives level and trigger select
`default_nettype none
interface pace_if;
    uart_flow_pkg::level_t level;
    logic [1:0]            sel;
    logic                  hold;
    logic                  trig_hit;
    modport pacer (input level, sel, output hold, trig_hit);
    modport ctrl  (output level, sel, input hold, trig_hit);
endinterface
`default_nettype wire

// >>> hdl/in_sync.sv
// Purpose: two-flop synchroniser for modem pins
// Assumes: pins idle high
// Notes:   first stage read only by second stage
`default_nettype none
module in_sync #(parameter int W = 4) (
    // clock
    input  wire logic         clk,
    // pins and result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_s
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    // no reset: the synced pins must show the real levels during reset,
    // otherwise a low pin gives a false change right after release
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            meta_q[i] <= pin_in[i];
            sync_q[i] <= meta_q[i];
        end
    end
    assign pin_s = sync_q;
endmodule
`default_nettype wire

// >>> hdl/rts_pacer.sv
// Purpose: receive fill level hysteresis for automatic rts
// Assumes: level is the receive fifo count on this clock
// Notes:   hold high means request-to-send must stay off
`include "uart_flow_consts.svh"
`default_nettype none
module rts_pacer (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // pacing link
    pace_if.pacer     p
);
    uart_flow_pkg::level_t trig_lvl;
    uart_flow_pkg::level_t up_lvl;
    uart_flow_pkg::level_t lo_lvl;
    logic                  above_q;
    logic                  hold_q;
    logic                  at_trig;
    assign trig_lvl = p.sel == 2'h0 ? `LVL_T0 : p.sel == 2'h1 ? `LVL_T1 :
                      p.sel == 2'h2 ? `LVL_T2 : `LVL_T3;
    assign up_lvl   = p.sel == 2'h0 ? `LVL_T1 : p.sel == 2'h1 ? `LVL_T2 :
                      p.sel == 2'h2 ? `LVL_T3 : `LVL_TOP;
    assign lo_lvl   = p.sel == 2'h0 ? `LVL_BOT : p.sel == 2'h1 ? `LVL_T0 :
                      p.sel == 2'h2 ? `LVL_T1 : `LVL_T2;
    assign at_trig  = p.level >= trig_lvl;
    always_ff @(posedge clk) begin
        above_q <= nrst & at_trig;
        if (!nrst)
            hold_q <= 1'b0;
        else if (p.level >= up_lvl)
            hold_q <= 1'b1;
        else if (p.level < lo_lvl)
            hold_q <= 1'b0;
    end
    assign p.hold     = hold_q;
    assign p.trig_hit = at_trig & ~above_q;
    upper_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        p.level >= up_lvl |=> hold_q) else $error("hold not set at upper");
    lower_free_a: assert property (@(posedge clk) disable iff (!nrst)
        p.level < lo_lvl |=> !hold_q) else $error("hold kept below lower");
endmodule
`default_nettype wire

// >>> hdl/uart_flow_top.sv
// Purpose: uart channel flow control, flow chars and reset state
// Assumes: apb slave on clk; fifos and shifters outside this block
// Notes:   answers every access two cycles after the access phase opens
`include "uart_flow_consts.svh"
`default_nettype none
module uart_flow_top (
    // clock and resets
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        por_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // modem pins
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        cd_n,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             general_output_two_n,
    // channel datapath
    input  wire logic [5:0]  rx_fifo_level,
    input  wire logic        rx_has_data,
    input  wire logic        tx_has_room,
    input  wire logic        tx_serial_in,
    output logic             tx_out,
    output logic             tx_stop,
    output logic             receive_ready_n,
    output logic             transmit_ready_n,
    // interrupt
    output logic             irq,
    output logic             irq_oe
);
    ////////////////////////////////////////////////////////////////////
    uart_flow_pkg::acc_state_t state_q, state_d;
    uart_flow_pkg::byte_t divisor_latch_low_q, divisor_latch_high_q;
    uart_flow_pkg::byte_t fractional_divisor_q, interrupt_enable_reg_q;
    uart_flow_pkg::byte_t fifo_control_reg_q, line_control_reg_q;
    uart_flow_pkg::byte_t modem_control_reg_q, line_status_reg_q;
    uart_flow_pkg::byte_t scratch_reg_q, enhanced_feature_control_q;
    uart_flow_pkg::byte_t flow_on_char_one_q, flow_on_char_two_q;
    uart_flow_pkg::byte_t flow_off_char_one_q, flow_off_char_two_q;
    uart_flow_pkg::byte_t modem_status_reg, interrupt_status_reg;
    uart_flow_pkg::byte_t wdat, rd_val;
    logic [3:0]           pins_s, prev_q, delta_q, delta_set;
    logic [`EV_W-1:0]     ev_stat_q, ev_mask_q, ev_set;
    logic [31:0]          prdata_q;
    logic                 pslverr_q, rts_n_q, dtr_n_q, op2_n_q, tx_q;
    logic                 tx_stop_q, receive_ready_n_n_q, transmit_ready_n_n_q, irq_q, irq_oe_q;
    logic                 do_wr, do_rd, unlock, auto_rts, auto_cts, mapped;
    logic                 rts_n_d;
    logic h_lo, h_hi, h_frac, h_ie, h_fc, h_is, h_lc, h_mc, h_ls, h_ms;
    logic h_sc, h_en, h_on1, h_on2, h_of1, h_of2, h_evs, h_evm;

    pace_if pace ();

    in_sync #(.W(4)) u_sync (
        .clk    (clk),
        .pin_in ({cd_n, ri_n, dsr_n, cts_n}),
        .pin_s  (pins_s)
    );

    rts_pacer u_pacer (
        .clk  (clk),
        .nrst (nrst),
        .p    (pace.pacer)
    );

    ////////////////////////////////////////////////////////////////////
    // apb access sequencing
    always_comb begin
        case (state_q)
            uart_flow_pkg::ACC_IDLE:
                state_d = (psel & penable) ? uart_flow_pkg::ACC_WAIT
                                           : uart_flow_pkg::ACC_IDLE;
            uart_flow_pkg::ACC_WAIT: state_d = uart_flow_pkg::ACC_DONE;
            default:                 state_d = uart_flow_pkg::ACC_IDLE;
        endcase
    end

    assign do_wr  = state_q == uart_flow_pkg::ACC_DONE && pwrite;
    assign do_rd  = state_q == uart_flow_pkg::ACC_DONE && !pwrite;
    assign wdat   = pwdata[7:0];
    assign h_lo   = paddr == `OFS_DIV_LO;
    assign h_hi   = paddr == `OFS_DIV_HI;
    assign h_frac = paddr == `OFS_FRAC;
    assign h_ie   = paddr == `OFS_INT_EN;
    assign h_fc   = paddr == `OFS_FIFO_CTL;
    assign h_is   = paddr == `OFS_INT_STAT;
    assign h_lc   = paddr == `OFS_LINE_CTL;
    assign h_mc   = paddr == `OFS_MDM_CTL;
    assign h_ls   = paddr == `OFS_LINE_ST;
    assign h_ms   = paddr == `OFS_MDM_ST;
    assign h_sc   = paddr == `OFS_SCRATCH;
    assign h_en   = paddr == `OFS_ENH;
    assign h_on1  = paddr == `OFS_ON1;
    assign h_on2  = paddr == `OFS_ON2;
    assign h_of1  = paddr == `OFS_OFF1;
    assign h_of2  = paddr == `OFS_OFF2;
    assign h_evs  = paddr == `OFS_EV_STAT;
    assign h_evm  = paddr == `OFS_EV_MASK;
    assign mapped = h_lo | h_hi | h_frac | h_ie | h_fc | h_is | h_lc |
                    h_mc | h_ls | h_ms | h_sc | h_en | h_on1 | h_on2 |
                    h_of1 | h_of2 | h_evs | h_evm;

    assign rd_val = ({8{h_lo}}  & divisor_latch_low_q)
                  | ({8{h_hi}}  & divisor_latch_high_q)
                  | ({8{h_frac}} & fractional_divisor_q)
                  | ({8{h_ie}}  & interrupt_enable_reg_q)
                  | ({8{h_fc}}  & fifo_control_reg_q)
                  | ({8{h_is}}  & interrupt_status_reg)
                  | ({8{h_lc}}  & line_control_reg_q)
                  | ({8{h_mc}}  & modem_control_reg_q)
                  | ({8{h_ls}}  & line_status_reg_q)
                  | ({8{h_ms}}  & modem_status_reg)
                  | ({8{h_sc}}  & scratch_reg_q)
                  | ({8{h_en}}  & enhanced_feature_control_q)
                  | ({8{h_on1}} & flow_on_char_one_q)
                  | ({8{h_on2}} & flow_on_char_two_q)
                  | ({8{h_of1}} & flow_off_char_one_q)
                  | ({8{h_of2}} & flow_off_char_two_q)
                  | ({8{h_evs}} & {5'h00, ev_stat_q})
                  | ({8{h_evm}} & {5'h00, ev_mask_q});

    always_ff @(posedge clk) begin
        state_q   <= nrst ? state_d : uart_flow_pkg::ACC_IDLE;
        prdata_q  <= (nrst && state_q == uart_flow_pkg::ACC_WAIT)
                     ? {24'h000000, rd_val} : 32'h00000000;
        pslverr_q <= nrst && state_q == uart_flow_pkg::ACC_WAIT && !mapped;
    end

    assign pready  = state_q[2];
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////
    // keeps locked enhanced bits when unlock is clear
    function automatic uart_flow_pkg::byte_t merge(
        input uart_flow_pkg::byte_t old_v,
        input uart_flow_pkg::byte_t new_v,
        input uart_flow_pkg::byte_t mask,
        input logic                 open_en);
        merge = open_en ? new_v : ((new_v & ~mask) | (old_v & mask));
    endfunction

    assign unlock   = enhanced_feature_control_q[`ENH_UNLOCK];
    assign auto_rts = enhanced_feature_control_q[`ENH_ARTS];
    assign auto_cts = enhanced_feature_control_q[`ENH_ACTS];

    // divisor survives the reset pin, only power-up loads it
    always_ff @(posedge clk) begin
        if (!por_n) begin
            divisor_latch_low_q  <= `RST_DIV_LO;
            divisor_latch_high_q <= `RST_ZERO;
        end else if (do_wr && h_lo) begin
            divisor_latch_low_q  <= wdat;
        end else if (do_wr && h_hi) begin
            divisor_latch_high_q <= wdat;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fractional_divisor_q       <= `RST_ZERO;
            interrupt_enable_reg_q     <= `RST_ZERO;
            fifo_control_reg_q         <= `RST_ZERO;
            line_control_reg_q         <= `RST_ZERO;
            modem_control_reg_q        <= `RST_ZERO;
            scratch_reg_q              <= `RST_SCRATCH;
            enhanced_feature_control_q <= `RST_ZERO;
            flow_on_char_one_q         <= `RST_ZERO;
            flow_on_char_two_q         <= `RST_ZERO;
            flow_off_char_one_q        <= `RST_ZERO;
            flow_off_char_two_q        <= `RST_ZERO;
            ev_mask_q                  <= '0;
        end else if (do_wr) begin
            if (h_frac && unlock)
                fractional_divisor_q <= wdat;
            if (h_ie)
                interrupt_enable_reg_q <= merge(interrupt_enable_reg_q,
                    wdat, `MASK_INT_EN, unlock);
            if (h_fc)
                fifo_control_reg_q <= merge(fifo_control_reg_q,
                    wdat, `MASK_FIFO, unlock);
            if (h_mc)
                modem_control_reg_q <= merge(modem_control_reg_q,
                    wdat, `MASK_MDM, unlock);
            if (h_lc)
                line_control_reg_q <= wdat;
            if (h_sc)
                scratch_reg_q <= wdat;
            if (h_en)
                enhanced_feature_control_q <= wdat;
            if (h_on1)
                flow_on_char_one_q <= wdat;
            if (h_on2)
                flow_on_char_two_q <= wdat;
            if (h_of1)
                flow_off_char_one_q <= wdat;
            if (h_of2)
                flow_off_char_two_q <= wdat;
            if (h_evm)
                ev_mask_q <= wdat[`EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // modem status: pins_s = {cd, ri, dsr, cts}, all active low
    assign delta_set = {prev_q[3] ^ pins_s[3], ~prev_q[2] & pins_s[2],
                        prev_q[1] ^ pins_s[1], prev_q[0] ^ pins_s[0]};
    assign modem_status_reg = {~pins_s, delta_q};

    always_ff @(posedge clk) begin
        prev_q  <= pins_s;
        if (!nrst)
            delta_q <= 4'h0;
        else
            delta_q <= ((do_rd && h_ms) ? 4'h0 : delta_q) | delta_set;
    end

    assign pace.level = rx_fifo_level;
    assign pace.sel   = fifo_control_reg_q[7:6];

    // event flags: a set in the clearing cycle wins
    assign ev_set[`EV_TRIG] = auto_rts & pace.trig_hit;
    assign ev_set[`EV_CTS]  = delta_set[0];
    assign ev_set[`EV_RTS]  = rts_n_d & ~rts_n_q;
    assign interrupt_status_reg = {{2{fifo_control_reg_q[`FC_FIFO_EN]}},
                                   5'h00, ~irq_q};

    always_ff @(posedge clk) begin
        if (!nrst)
            ev_stat_q <= '0;
        else
            ev_stat_q <= (ev_stat_q &
                ~(do_wr && h_evs ? wdat[`EV_W-1:0] : '0)) | ev_set;
    end

    ////////////////////////////////////////////////////////////////////
    // pins
    assign rts_n_d = !auto_rts ? ~modem_control_reg_q[`MC_RTS]
                   : !modem_control_reg_q[`MC_RTS] ? 1'b1
                   : pace.hold;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rts_n_q   <= 1'b1;
            dtr_n_q   <= 1'b1;
            op2_n_q   <= 1'b1;
            tx_q      <= 1'b1;
            receive_ready_n_n_q <= 1'b1;
            transmit_ready_n_n_q <= 1'b0;
            irq_q     <= 1'b0;
            irq_oe_q  <= 1'b0;
            tx_stop_q <= 1'b0;
            line_status_reg_q <= `RST_LINE_ST;
        end else begin
            rts_n_q   <= rts_n_d;
            dtr_n_q   <= ~modem_control_reg_q[`MC_DTR];
            op2_n_q   <= ~modem_control_reg_q[`MC_OP2];
            tx_q      <= tx_serial_in;
            receive_ready_n_n_q <= ~rx_has_data;
            transmit_ready_n_n_q <= ~tx_has_room;
            irq_q     <= |(ev_stat_q & ev_mask_q);
            irq_oe_q  <= modem_control_reg_q[`MC_OP2];
            tx_stop_q <= auto_cts & pins_s[0];
            line_status_reg_q <= {1'b0, tx_has_room, tx_has_room,
                                  4'h0, rx_has_data};
        end
    end

    assign rts_n                = rts_n_q;
    assign dtr_n                = dtr_n_q;
    assign general_output_two_n = op2_n_q;
    assign tx_out               = tx_q;
    assign tx_stop              = tx_stop_q;
    assign receive_ready_n      = receive_ready_n_n_q;
    assign transmit_ready_n     = transmit_ready_n_n_q;
    assign irq                  = irq_q;
    assign irq_oe               = irq_oe_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence after_rst_s;
        $past(!nrst);
    endsequence
    sequence wr_on1_s;
        do_wr && h_on1 ##1 1'b1;
    endsequence

    arts_off_a: assert property (after_rst_s |-> !auto_rts)
        else $error("auto rts on after reset");
    arts_hold_a: assert property (
        auto_rts && modem_control_reg_q[`MC_RTS] && pace.hold |=> rts_n)
        else $error("rts low during hold");
    arts_low_a: assert property (
        auto_rts && modem_control_reg_q[`MC_RTS] && !pace.hold |=> !rts_n)
        else $error("rts high without hold");
    arts_gate_a: assert property (
        auto_rts && !modem_control_reg_q[`MC_RTS] |=> rts_n)
        else $error("rts low before software asserts it");
    rts_gpo_a: assert property (
        !auto_rts ##1 !$past(!nrst) |->
        rts_n == !$past(modem_control_reg_q[`MC_RTS]))
        else $error("rts not following modem control");
    cts_stop_a: assert property (auto_cts && pins_s[0] |=> tx_stop)
        else $error("transmit not stopped by cts");
    char_store_a: assert property (
        wr_on1_s |-> flow_on_char_one_q == $past(pwdata[7:0], 1))
        else $error("flow char not stored");
    div_keep_a: assert property (@(posedge clk) disable iff (!por_n)
        !nrst && !do_wr |=> $stable({divisor_latch_high_q,
                                     divisor_latch_low_q}))
        else $error("divisor changed by reset pin");
    reg_reset_a: assert property (after_rst_s |->
        interrupt_status_reg == `RST_INT_STAT &&
        line_status_reg_q == `RST_LINE_ST && scratch_reg_q == `RST_SCRATCH)
        else $error("reset values wrong");
    mdm_reset_a: assert property (after_rst_s |-> delta_q == 4'h0)
        else $error("modem deltas not cleared");
    pin_reset_a: assert property (after_rst_s |-> tx_out &&
        general_output_two_n && rts_n && dtr_n && receive_ready_n &&
        !transmit_ready_n && !irq_oe)
        else $error("pin reset state wrong");
    enh_lock_a: assert property (do_wr && h_ie && !unlock |=>
        interrupt_enable_reg_q[7:4] == $past(interrupt_enable_reg_q[7:4]))
        else $error("locked enhanced bits changed");
endmodule
`default_nettype wire

// >>> dv/remote_modem.sv
// Purpose: far-end modem model driving the handshake pins
// Assumes: the bench asks for a stall through one control input
// Notes:   unused pins stay deasserted (high)
`default_nettype none
module remote_modem (
    // clock
    input  wire logic clk,
    // bench control
    input  wire logic stall,
    // handshake pins
    input  wire logic rts_n,
    output logic      cts_n,
    output logic      dsr_n,
    output logic      ri_n,
    output logic      cd_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cts_n, dsr_n, ri_n, cd_n} = 4'hF;
    // cts high halts the near transmitter, low lets it resume
    always @(posedge clk) cts_n <= stall;
endmodule
`default_nettype wire

// >>> dv/uart_flow_top_bench.sv
// Purpose: self-checking bench for uart_flow_top
// Assumes: 40 MHz clock, apb master tasks in this file
// Notes:   pin reset check and register table loop first, then pin scenarios
`include "uart_flow_consts.svh"
`default_nettype none
module uart_flow_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d;} row_t;
    logic        clk = 0, nrst = 0, por_n = 0, stall = 0;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 0, rd;
    logic [31:0] pwdata = 0, prdata;
    logic        cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, op2_n, last_err;
    logic [5:0]  lvl = 0;
    logic        tx_out, tx_stop, rxr_n, txr_n, irq, irq_oe;
    int          err_count = 0, n_compared = 0;
    row_t rows[] = '{
        '{0,`OFS_DIV_LO,8'h01}, '{0,`OFS_DIV_HI,8'h00}, '{0,`OFS_FRAC,8'h00},
        '{0,`OFS_INT_EN,8'h00}, '{0,`OFS_FIFO_CTL,8'h00},
        '{0,`OFS_INT_STAT,8'h01}, '{0,`OFS_LINE_CTL,8'h00},
        '{0,`OFS_MDM_CTL,8'h00}, '{0,`OFS_LINE_ST,8'h60},
        '{0,`OFS_MDM_ST,8'h10}, '{0,`OFS_SCRATCH,8'hFF}, '{0,`OFS_ENH,8'h00},
        '{0,`OFS_ON1,8'h00}, '{0,`OFS_ON2,8'h00}, '{0,`OFS_OFF1,8'h00},
        '{0,`OFS_OFF2,8'h00}, '{1,`OFS_ON1,8'h11}, '{1,`OFS_ON2,8'h22},
        '{1,`OFS_OFF1,8'h13}, '{1,`OFS_OFF2,8'h93}, '{0,`OFS_ON1,8'h11},
        '{0,`OFS_ON2,8'h22}, '{0,`OFS_OFF1,8'h13}, '{0,`OFS_OFF2,8'h93},
        '{0,8'h48,8'h00}};

    uart_flow_top i_uart_flow_top (.clk(clk), .nrst(nrst), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .cd_n(cd_n), .rts_n(rts_n), .dtr_n(dtr_n),
        .general_output_two_n(op2_n), .rx_fifo_level(lvl),
        .rx_has_data(1'b0), .tx_has_room(1'b1), .tx_serial_in(1'b1),
        .tx_out(tx_out), .tx_stop(tx_stop), .receive_ready_n(rxr_n),
        .transmit_ready_n(txr_n), .irq(irq), .irq_oe(irq_oe));
    remote_modem i_remote_modem (.clk(clk), .stall(stall), .rts_n(rts_n),
        .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));

    always #12.5 clk = ~clk;

    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        // this wait ends when pready goes high; the watchdog ends a hung one
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("wait", n[7:0], 8'h03);
        rd       = prdata[7:0];
        last_err = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask

    task automatic wt(int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(3000 * 25);
        err_count++;
        finish_test();
    end

    initial begin
        wt(6);
        chk("pins", {rts_n, dtr_n, op2_n, tx_out, rxr_n, txr_n, irq_oe},
            8'h7C);
        nrst  <= 1;
        por_n <= 1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("reg", rd, rows[i].d);
        end
        chk("slverr", last_err, 1);
        // divisor survives the reset pin, scratch does not
        apb(1, `OFS_DIV_LO, 8'h55);
        apb(1, `OFS_SCRATCH, 8'h3C);
        nrst <= 0;
        wt(3);
        nrst <= 1;
        apb(0, `OFS_DIV_LO, 0);
        chk("div_lo", rd, 8'h55);
        apb(0, `OFS_SCRATCH, 0);
        chk("scratch", rd, 8'hFF);
        apb(1, `OFS_MDM_CTL, 8'h0A);
        wt(3);
        chk("gpo", {rts_n, irq_oe}, 8'h01);
        apb(1, `OFS_ENH, 8'h50);
        apb(1, `OFS_EV_MASK, 8'h07);
        lvl <= `LVL_T0;
        wt(4);
        chk("trig", {irq, rts_n}, 8'h02);
        lvl <= `LVL_T1;
        wt(4);
        chk("rts up", rts_n, 1);
        lvl <= `LVL_BOT + 6'h01;
        wt(4);
        chk("rts hold", rts_n, 1);
        lvl <= `LVL_BOT - 6'h01;
        wt(4);
        chk("rts low", rts_n, 0);
        apb(1, `OFS_EV_STAT, 8'hFF);
        wt(3);
        chk("irq clr", irq, 0);
        apb(1, `OFS_ENH, 8'hD0);
        stall <= 1;
        wt(6);
        chk("stop", {tx_stop, irq}, 8'h03);
        stall <= 0;
        wt(6);
        chk("resume", tx_stop, 0);
        // cts went high and low: delta stays until read, then clears
        apb(0, `OFS_MDM_ST, 0);
        chk("msr delta", rd, 8'h11);
        apb(0, `OFS_MDM_ST, 0);
        chk("msr clear", rd, 8'h10);
        apb(1, `OFS_ENH, 8'hC0);
        apb(1, `OFS_INT_EN, 8'hFF);
        apb(0, `OFS_INT_EN, 0);
        chk("locked", rd, 8'h0F);
        finish_test();
    end
endmodule
`default_nettype wire
